// >>> rtl/sia_aggregator.sv
// system interrupt aggregator: raw vsync status, combined status, enable mask and host interrupt
`timescale 1ns/100ps
`default_nettype none
module sia_aggregator (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // register access
    input  wire sia_pkg::sia_req_t    reg_req,
    output logic [31:0]               reg_rdata,
    output logic                      reg_rvalid,
    // event sources
    input  wire logic [4:0]           vsync_pins,
    input  wire sia_pkg::sia_periph_t periph_events,
    // polarity control from the miscellaneous control register
    input  wire logic                 irq_polarity_invert,
    // host interrupt
    output logic                      host_irq
);
    logic [4:0]  raw_status;
    logic [4:0]  clear_vec;
    logic [31:0] enable_mask_reg;
    logic [31:0] combined_status;
    logic [31:0] irq_source;
    logic        irq_any;
    logic        raw_clear_wr;
    logic        host_irq_next;

    // write decode of the raw clear offset
    assign raw_clear_wr = reg_req.wr && (reg_req.addr == sia_pkg::RAW_VSYNC_OFFS);

    // only ones in the write clear; upper data bits ignored
    assign clear_vec = raw_clear_wr ? reg_req.wdata[4:0] : 5'h00;

    // one sticky catcher per vsync source
    for (genvar i = 0; i < sia_pkg::VSYNC_COUNT; i++) begin : g_vsync
        sia_vsync_catch u_catch (
            .ref_clk    (ref_clk),
            .sys_rst    (sys_rst),
            .vsync_pin  (vsync_pins[i]),
            .clear_req  (clear_vec[i]),
            .status_bit (raw_status[i])
        );
    end

    // mask is plain read/write, reserved bits kept at zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            enable_mask_reg <= sia_pkg::ENABLE_MASK_RESET;
        end else if (reg_req.wr && (reg_req.addr == sia_pkg::ENABLE_MASK_OFFS)) begin
            enable_mask_reg <= reg_req.wdata & sia_pkg::ENABLE_VALID_MASK;
        end
    end

    // combined status assembly; peripheral levels are same-clock logic, no sync needed
    always_comb begin
        combined_status = 32'h0000_0000;
        combined_status[31:25] = periph_events.gpio_event;
        combined_status[sia_pkg::BIT_TWO_WIRE]    = periph_events.two_wire_event;
        combined_status[sia_pkg::BIT_PULSE_WIDTH] = periph_events.pulse_width_event;
        combined_status[sia_pkg::BIT_DMA_ONE]     = periph_events.dma_channel_one_event;
        combined_status[sia_pkg::BIT_SERIAL_ONE]  = periph_events.serial_port1_event;
        combined_status[sia_pkg::BIT_SERIAL_ZERO] = periph_events.serial_port0_event;
        combined_status[sia_pkg::BIT_DRAW_ENGINE] = periph_events.draw_engine_event;
        // vsync bits mirror the raw status
        combined_status[4:0] = raw_status;
    end

    // host bus gated by mask bit 8 although its status bit reads zero
    always_comb begin
        irq_source = combined_status;
        irq_source[sia_pkg::BIT_HOST_BUS] = periph_events.host_bus_event;
    end

    // per-source gating; any enabled source raises irq_any
    assign irq_any = |(irq_source & enable_mask_reg);

    assign host_irq_next = irq_any ^ irq_polarity_invert;

    // registered interrupt output, one cycle behind its sources
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= host_irq_next;
        end
    end

    // read data is registered; unmapped offsets return zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    sia_pkg::RAW_VSYNC_OFFS:   reg_rdata <= {27'h0000000, raw_status};
                    sia_pkg::COMBINED_OFFS:    reg_rdata <= combined_status & sia_pkg::STATUS_VALID_MASK;
                    sia_pkg::ENABLE_MASK_OFFS: reg_rdata <= enable_mask_reg;
                    default:                   reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // a write of one to a set bit 1 with no new edge in the same cycle
    sequence s_clear_bit1;
        raw_clear_wr && reg_req.wdata[1] && raw_status[1] && !g_vsync[1].u_catch.rise;
    endsequence

    // ones clear unless an edge lands in the same cycle
    AST_RAW_CLEAR_ONES: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (raw_clear_wr && reg_req.wdata[0] && !g_vsync[0].u_catch.rise) |=> !raw_status[0])
        else $error("raw bit 0 not cleared by write of one");

    AST_RAW_CLEAR_ZEROS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (raw_clear_wr && !reg_req.wdata[3] && raw_status[3]) |=> raw_status[3])
        else $error("zero write disturbed raw bit 3");

    // raw clear leaves the mask alone
    AST_CLEAR_NO_MASK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        raw_clear_wr |=> $stable(enable_mask_reg))
        else $error("raw clear altered the mask");

    AST_STATUS_RESERVED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == sia_pkg::COMBINED_OFFS)
            |=> (reg_rdata[24:13] == 12'h000 && !reg_rdata[10] && !reg_rdata[8]))
        else $error("reserved status bits read nonzero");

    AST_GPIO_REPORT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == sia_pkg::COMBINED_OFFS)
            |=> reg_rdata[31:25] == $past(periph_events.gpio_event))
        else $error("gpio status mismatch");

    AST_VSYNC_MIRROR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == sia_pkg::COMBINED_OFFS)
            |=> reg_rdata[4:0] == $past(raw_status))
        else $error("combined vsync bits differ from raw");

    AST_PERIPH_REPORT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == sia_pkg::COMBINED_OFFS)
            |=> (reg_rdata[12] == $past(periph_events.two_wire_event)
                 && reg_rdata[11] == $past(periph_events.pulse_width_event)
                 && reg_rdata[9] == $past(periph_events.dma_channel_one_event)
                 && reg_rdata[7:5] == $past({periph_events.serial_port1_event,
                                             periph_events.serial_port0_event,
                                             periph_events.draw_engine_event})))
        else $error("peripheral status mismatch");

    AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_req.wr && reg_req.addr == sia_pkg::ENABLE_MASK_OFFS)
            |=> enable_mask_reg == ($past(reg_req.wdata) & sia_pkg::ENABLE_VALID_MASK))
        else $error("mask write not stored");

    // host bus gated by bit 8
    AST_HOST_BUS_GATE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (periph_events.host_bus_event && enable_mask_reg[8]) |=> host_irq != $past(irq_polarity_invert))
        else $error("host bus source not gated to interrupt");

    AST_MASKED_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (enable_mask_reg == 32'h0000_0000) |=> host_irq == $past(irq_polarity_invert))
        else $error("interrupt with all sources disabled");

    // polarity applied; skipped on the edge after reset, where the flop still holds zero
    AST_INVERT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !$past(sys_rst) |-> host_irq == ($past(irq_any) ^ $past(irq_polarity_invert)))
        else $error("interrupt polarity wrong");

    AST_RAW_CLEAR_BIT1: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_clear_bit1 |=> !raw_status[1])
        else $error("raw bit 1 not cleared by write of one");

    // enabled raw source raises the line
    AST_ANY_ENABLED: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|(raw_status & enable_mask_reg[4:0]) && !irq_polarity_invert) |=> host_irq)
        else $error("enabled raw source did not raise interrupt");

endmodule : sia_aggregator
`default_nettype wire

// >>> rtl/sia_pkg.sv
// package: register map, field positions and carrier types for the interrupt aggregator
package sia_pkg;

    // register byte offsets
    localparam logic [7:0] RAW_VSYNC_OFFS    = 8'h20;
    localparam logic [7:0] COMBINED_OFFS     = 8'h24;
    localparam logic [7:0] ENABLE_MASK_OFFS  = 8'h28;

    // reset values
    localparam logic [31:0] RAW_VSYNC_RESET  = 32'h0000_0000;
    localparam logic [31:0] ENABLE_MASK_RESET = 32'h0000_0000;

    // vsync source count and status bit positions of every source
    localparam int          VSYNC_COUNT       = 5;
    localparam int          BIT_LEGACY_VGA    = 0;
    localparam int          BIT_PANEL         = 1;
    localparam int          BIT_CRT           = 2;
    localparam int          BIT_VIDEO_PORT0   = 3;
    localparam int          BIT_VIDEO_PORT1   = 4;
    localparam int          BIT_DRAW_ENGINE   = 5;
    localparam int          BIT_SERIAL_ZERO   = 6;
    localparam int          BIT_SERIAL_ONE    = 7;
    localparam int          BIT_HOST_BUS      = 8;
    localparam int          BIT_DMA_ONE       = 9;
    localparam int          BIT_PULSE_WIDTH   = 11;
    localparam int          BIT_TWO_WIRE      = 12;
    localparam int          GPIO_LSB          = 25;
    localparam int          GPIO_COUNT        = 7;

    // writable / reportable bit sets
    localparam logic [31:0] STATUS_VALID_MASK = 32'hfe00_1aff;
    localparam logic [31:0] ENABLE_VALID_MASK = 32'hfe00_1bff;

    // register access request from the host side
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } sia_req_t;

    // peripheral event levels (each level is 1 while that unit requests service)
    typedef struct packed {
        logic [6:0] gpio_event;
        logic       two_wire_event;
        logic       pulse_width_event;
        logic       dma_channel_one_event;
        logic       host_bus_event;
        logic       serial_port1_event;
        logic       serial_port0_event;
        logic       draw_engine_event;
    } sia_periph_t;

endpackage : sia_pkg

// >>> rtl/sia_vsync_catch.sv
// one vsync source: pin synchroniser, rising edge detect and sticky status bit
`timescale 1ns/100ps
`default_nettype none
module sia_vsync_catch (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // asynchronous vsync level from the display timing logic
    input  wire logic vsync_pin,
    // clear request from the register decode
    input  wire logic clear_req,
    // sticky status
    output logic      status_bit
);
    logic sync1_reg;
    logic sync2_reg;
    logic last_reg;
    logic rise;

    // two flops before any logic looks at the pin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg  <= 1'b0;
        end else begin
            sync1_reg <= vsync_pin;
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    assign rise = sync2_reg & ~last_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_bit <= 1'b0;
        end else if (rise) begin
            status_bit <= 1'b1;
        end else if (clear_req) begin
            status_bit <= 1'b0;
        end
    end

    // edge always lands in the status bit
    AST_VSYNC_EDGE_SETS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rise |=> status_bit)
        else $error("vsync edge did not set status");

    AST_STATUS_HOLDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (status_bit && !clear_req) |=> status_bit)
        else $error("status dropped without clear");

endmodule : sia_vsync_catch
`default_nettype wire

// >>> dv/tb_sia_aggregator.sv
// self-checking bench for the system interrupt aggregator
`timescale 1ns/100ps
`default_nettype none
module tb_sia_aggregator;
    // design ports and bench state
    logic                 ref_clk = 1'b0;
    logic                 sys_rst = 1'b1;
    sia_pkg::sia_req_t    reg_req = '0;
    logic [31:0]          reg_rdata;
    logic                 reg_rvalid;
    logic [4:0]           vsync_pins = 5'h00;
    sia_pkg::sia_periph_t periph_events = '0;
    logic                 irq_polarity_invert = 1'b0;
    logic                 host_irq;
    int                   bad_count = 0;
    int                   total_checks = 0;
    integer               seed = 32'h82fc;
    logic [31:0]          exp_q[$];
    logic [31:0]          mask_val;
    logic                 irq_exp;

    // 50 ns period
    always #25 ref_clk = ~ref_clk;

    sia_aggregator sia_aggregator_i (
        .ref_clk             (ref_clk),
        .sys_rst             (sys_rst),
        .reg_req             (reg_req),
        .reg_rdata           (reg_rdata),
        .reg_rvalid          (reg_rvalid),
        .vsync_pins          (vsync_pins),
        .periph_events       (periph_events),
        .irq_polarity_invert (irq_polarity_invert),
        .host_irq            (host_irq)
    );

    // one comparison, counted; mismatch reported at once
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // launch a request just after the edge; held until the next call or idle
    task automatic op(logic r, logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
        @(posedge ref_clk);
        #1;
        reg_req = '{rd: r, wr: w, addr: a, wdata: d};
        if (r)
            exp_q.push_back(e);
    endtask : op

    task automatic idle(int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            reg_req = '0;
        end
    endtask : idle

    // host_irq lags its causes by one cycle; look two edges on
    task automatic irq_is(logic e);
        repeat (2) @(posedge ref_clk);
        #2;
        check("host_irq", {31'h0, host_irq}, {31'h0, e});
    endtask : irq_is

    // expected combined word, built bit by bit from the sources
    function automatic logic [31:0] comb(sia_pkg::sia_periph_t p, logic [4:0] raw);
        return {p.gpio_event, 12'h000, p.two_wire_event, p.pulse_width_event, 1'b0,
                p.dma_channel_one_event, 1'b0, p.serial_port1_event, p.serial_port0_event,
                p.draw_engine_event, raw};
    endfunction : comb

    // scoreboard: each read answer meets the oldest note, sampled mid-cycle
    always @(negedge ref_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                check("spare answer", 32'h1, 32'h0);
            else
                check("read data", reg_rdata, exp_q.pop_front());
        end
    end

    // hang guard, about eighteen times the expected run
    initial begin
        #(50 * 4000);
        bad_count++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        op(1'b1, 1'b0, sia_pkg::RAW_VSYNC_OFFS, 32'h0, sia_pkg::RAW_VSYNC_RESET);
        op(1'b1, 1'b0, sia_pkg::COMBINED_OFFS, 32'h0, 32'h0000_0000);
        op(1'b1, 1'b0, sia_pkg::ENABLE_MASK_OFFS, 32'h0, sia_pkg::ENABLE_MASK_RESET);
        op(1'b1, 1'b0, 8'h30, 32'h0, 32'h0000_0000);
        idle(1);
        irq_is(1'b0);
        $display("test reset values done");
        // all-ones mask write reads back at once as the valid bits only; status is read-only
        op(1'b0, 1'b1, sia_pkg::ENABLE_MASK_OFFS, 32'hffff_ffff, 32'h0);
        op(1'b1, 1'b0, sia_pkg::ENABLE_MASK_OFFS, 32'h0, sia_pkg::ENABLE_VALID_MASK);
        op(1'b0, 1'b1, sia_pkg::COMBINED_OFFS, 32'hffff_ffff, 32'h0);
        op(1'b1, 1'b0, sia_pkg::COMBINED_OFFS, 32'h0, 32'h0000_0000);
        idle(1);
        $display("test mask access done");
        // random sources, sparse random mask, random polarity
        for (int i = 0; i < 24; i++) begin
            mask_val = $random(seed) & $random(seed);
            op(1'b0, 1'b1, sia_pkg::ENABLE_MASK_OFFS, mask_val, 32'h0);
            idle(1);
            periph_events = sia_pkg::sia_periph_t'(14'($random(seed)));
            irq_polarity_invert = 1'($random(seed));
            irq_exp = (|(comb(periph_events, 5'h00) & mask_val))
                      | (periph_events.host_bus_event & mask_val[8]);
            irq_is(irq_exp ^ irq_polarity_invert);
            op(1'b1, 1'b0, sia_pkg::COMBINED_OFFS, 32'h0, comb(periph_events, 5'h00));
            op(1'b1, 1'b0, sia_pkg::ENABLE_MASK_OFFS, 32'h0, mask_val & sia_pkg::ENABLE_VALID_MASK);
            idle(1);
        end
        $display("test random sources done");
        // vsync edges become sticky; ones clear, zeros keep, upper bits touch nothing
        mask_val = 32'h0000_0004;
        op(1'b0, 1'b1, sia_pkg::ENABLE_MASK_OFFS, mask_val, 32'h0);
        irq_polarity_invert = 1'b0;
        vsync_pins = 5'h15;
        idle(5);
        vsync_pins = 5'h00;
        idle(2);
        irq_is(1'b1);
        op(1'b1, 1'b0, sia_pkg::RAW_VSYNC_OFFS, 32'h0, 32'h0000_0015);
        op(1'b0, 1'b1, sia_pkg::RAW_VSYNC_OFFS, 32'hffff_ffe4, 32'h0);
        op(1'b1, 1'b0, sia_pkg::RAW_VSYNC_OFFS, 32'h0, 32'h0000_0011);
        op(1'b1, 1'b0, sia_pkg::COMBINED_OFFS, 32'h0, comb(periph_events, 5'h11));
        idle(1);
        irq_is(1'b0);
        op(1'b0, 1'b1, sia_pkg::RAW_VSYNC_OFFS, 32'h0000_001f, 32'h0);
        op(1'b1, 1'b0, sia_pkg::RAW_VSYNC_OFFS, 32'h0, 32'h0000_0000);
        idle(1);
        $display("test vsync status done");
        // second reset in mid-run returns the mask to zero
        op(1'b0, 1'b1, sia_pkg::ENABLE_MASK_OFFS, 32'hffff_ffff, 32'h0);
        idle(1);
        sys_rst = 1'b1;
        idle(2);
        sys_rst = 1'b0;
        op(1'b1, 1'b0, sia_pkg::ENABLE_MASK_OFFS, 32'h0, sia_pkg::ENABLE_MASK_RESET);
        idle(3);
        check("pending reads", 32'(exp_q.size()), 32'h0);
        $display("test second reset done");
        test_done();
    end
endmodule : tb_sia_aggregator
`default_nettype wire
